// >>> core/bitstream_pkg.sv
// Constants and carrier types for the one-bit audio stream input block.
// Assumes a 25 MHz system clock and a separate stream bit clock port.
package bitstream_pkg;

    localparam logic [2:0] MODE_RESET_VAL = 3'h0;
    localparam logic MUTE_RESET_VAL = 1'h1;
    localparam logic PDN_RESET_VAL = 1'h1;
    localparam logic CP_EN_RESET_VAL = 1'h0;
    // Ratio check window, in ns and then in system clock cycles
    localparam int RATIO_WIN_NS = 10240;
    localparam int SYS_CLK_NS = 40;
    localparam logic [8:0] RATIO_WIN_CYC = 9'(RATIO_WIN_NS / SYS_CLK_NS);
    // Mode select bit positions
    localparam int OSR_SEL_BIT = 2;
    localparam int RATIO_SEL_LSB = 0;
    // Bit-clock edge count bounds per window, indexed by ratio code
    localparam logic [8:0] EDGE_MIN_64X [4] = '{9'h03C, 9'h028, 9'h01E, 9'h014};
    localparam logic [8:0] EDGE_MAX_64X [4] = '{9'h046, 9'h030, 9'h024, 9'h018};
    localparam logic [8:0] EDGE_MIN_128X [4] = '{9'h078, 9'h050, 9'h03C, 9'h028};
    localparam logic [8:0] EDGE_MAX_128X [4] = '{9'h08C, 9'h05C, 9'h046, 9'h030};

    typedef enum logic [1:0] {
        ST_LOWPWR = 2'b00,
        ST_WAIT_PDN = 2'b01,
        ST_RUN = 2'b10
    } run_state_type;

    typedef struct packed {
        logic bitstream_mode_pin;
        logic mode_sel_2;
        logic mode_sel_1;
        logic mode_sel_0;
    } mode_pins_type;

    typedef struct packed {
        logic chan_a;
        logic chan_b;
        logic valid;
    } stream_pair_type;

endpackage

// >>> core/stream_capture.sv
// Captures the two stream data inputs on the stream bit clock and passes
// each bit pair to the system clock domain with a toggle handshake.
// Assumes the bit clock is slower than half the system clock.
`timescale 1ns/1ps
`default_nettype none
module stream_capture (
    input wire logic stream_bit_clock,
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic chan_a_in,
    input wire logic chan_b_in,
    output var bitstream_pkg::stream_pair_type pair_out,
    output logic edge_pulse
);

    typedef struct packed {
        logic a;
        logic b;
        logic a_alt;
        logic b_alt;
        logic tog;
    } link_state_type;

    typedef struct packed {
        logic tog_s1;
        logic tog_s2;
        logic tog_s3;
        bitstream_pkg::stream_pair_type pair;
    } sys_state_type;

    link_state_type link_r;
    link_state_type link_nxt;
    sys_state_type sys_r;
    sys_state_type sys_nxt;
    logic link_rst_s1_r;
    logic link_rst_s2_r;

    // ****************************************
    // Link domain: rising edge sampling
    // ****************************************
    always_ff @(posedge stream_bit_clock) begin
        link_rst_s1_r <= rst;
        link_rst_s2_r <= link_rst_s1_r;
    end

    always_comb begin
        link_nxt = link_r;
        // Two slots, picked by the current toggle, so each bit holds two periods
        if (link_r.tog) begin
            link_nxt.a_alt = chan_a_in;
            link_nxt.b_alt = chan_b_in;
        end else begin
            link_nxt.a = chan_a_in;
            link_nxt.b = chan_b_in;
        end
        link_nxt.tog = ~link_r.tog;
        if (link_rst_s2_r) begin
            link_nxt = '0;
        end
    end

    always_ff @(posedge stream_bit_clock) begin
        link_r <= link_nxt;
    end

    // ****************************************
    // System domain: toggle crossing
    // ****************************************
    always_comb begin
        sys_nxt = sys_r;
        sys_nxt.tog_s1 = link_r.tog;
        sys_nxt.tog_s2 = sys_r.tog_s1;
        sys_nxt.tog_s3 = sys_r.tog_s2;
        sys_nxt.pair.valid = 1'b0;
        // Slot named by the landed toggle is stable for two bit periods
        if (sys_r.tog_s2 != sys_r.tog_s3) begin
            sys_nxt.pair.chan_a = sys_r.tog_s2 ? link_r.a : link_r.a_alt;
            sys_nxt.pair.chan_b = sys_r.tog_s2 ? link_r.b : link_r.b_alt;
            sys_nxt.pair.valid = 1'b1;
        end
        if (rst) begin
            sys_nxt = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        sys_r <= sys_nxt;
    end

    assign pair_out = sys_r.pair;
    assign edge_pulse = sys_r.pair.valid;

endmodule
`default_nettype wire

// >>> core/bitstream_audio_input_ctrl.sv
// Top of the one-bit audio stream input block: reset, power-down, mode
// decode, ratio check and mute control.
// Assumes pins arrive asynchronously and a stream bit clock of its own.
//
// Summary of operation
// - Hardware config: reset high gives low power, default state; low runs.
// - Control config: reset high loads all registers with reset values and enters low power.
// - Control config: after reset, stay idle until power-down bit is cleared.
// - Control accesses are ignored while reset is held high.
// - Both stream data inputs are clocked in by the stream bit clock.
// - Select 2 picks 64x/128x; selects 1:0 pick the clock ratio.
// - Mute outputs high in init, reset, bad ratio, and in control config on mute or power-down.
`timescale 1ns/1ps
`default_nettype none
module bitstream_audio_input_ctrl (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic STREAM_BIT_CLOCK,
    input wire logic STREAM_IN_CHAN_A,
    input wire logic STREAM_IN_CHAN_B,
    input wire logic BITSTREAM_MODE_PIN,
    input wire logic MODE_SEL_2,
    input wire logic MODE_SEL_1,
    input wire logic MODE_SEL_0,
    input wire logic CTRL_PORT_CFG,
    input wire logic CP_WRITE,
    input wire logic CP_EN_WDATA,
    input wire logic POWER_DOWN_WDATA,
    input wire logic MUTE_WDATA,
    input wire logic [2:0] CP_MODE_WDATA,
    output logic POWER_DOWN_BIT,
    output logic CP_ENABLE,
    output logic LOW_POWER,
    output logic STREAM_ACTIVE,
    output logic RATIO_OK,
    output logic STREAM_BIT_A,
    output logic STREAM_BIT_B,
    output logic STREAM_VALID,
    output logic MUTE_CTL_CHAN_A,
    output logic MUTE_CTL_CHAN_B
);

    typedef struct packed {
        bitstream_pkg::mode_pins_type pins_s1;
        bitstream_pkg::mode_pins_type pins_s2;
        bitstream_pkg::run_state_type state;
        logic power_down_bit;
        logic cp_en;
        logic soft_mute;
        logic [2:0] cp_mode;
        logic [8:0] win_cnt;
        logic [8:0] edge_cnt;
        logic ratio_ok;
        logic bit_a;
        logic bit_b;
        logic valid;
        logic mute;
    } ctrl_state_type;

    ctrl_state_type st_r;
    ctrl_state_type st_nxt;
    bitstream_pkg::stream_pair_type pair;
    logic edge_pulse;
    logic [2:0] mode_eff;
    logic stream_sel;
    logic [1:0] ratio_code;
    logic [8:0] edge_min;
    logic [8:0] edge_max;
    logic cp_take;
    logic cp_take_locked;
    logic mute_cause;

    // ****************************************
    // Stream capture
    // ****************************************
    stream_capture u_capture (
        .stream_bit_clock(STREAM_BIT_CLOCK),
        .sys_clk(SYS_CLK),
        .rst(RST),
        .chan_a_in(STREAM_IN_CHAN_A),
        .chan_b_in(STREAM_IN_CHAN_B),
        .pair_out(pair),
        .edge_pulse(edge_pulse)
    );

    // ****************************************
    // Mode decode
    // ****************************************
    always_comb begin
        if (CTRL_PORT_CFG) begin
            mode_eff = st_r.cp_mode;
        end else begin
            mode_eff = {st_r.pins_s2.mode_sel_2, st_r.pins_s2.mode_sel_1,
                st_r.pins_s2.mode_sel_0};
        end
        stream_sel = st_r.pins_s2.bitstream_mode_pin;
        ratio_code = mode_eff[bitstream_pkg::RATIO_SEL_LSB +: 2];
        if (mode_eff[bitstream_pkg::OSR_SEL_BIT]) begin
            edge_min = bitstream_pkg::EDGE_MIN_128X[ratio_code];
            edge_max = bitstream_pkg::EDGE_MAX_128X[ratio_code];
        end else begin
            edge_min = bitstream_pkg::EDGE_MIN_64X[ratio_code];
            edge_max = bitstream_pkg::EDGE_MAX_64X[ratio_code];
        end
    end

    // ****************************************
    // Control port write decode
    // ****************************************
    always_comb begin
        cp_take = CP_WRITE && !RST;
        cp_take_locked = cp_take && st_r.cp_en;
    end

    // ****************************************
    // Mute causes
    // ****************************************
    always_comb begin
        mute_cause = st_r.state != bitstream_pkg::ST_RUN;
        mute_cause = mute_cause || !st_r.ratio_ok;
        mute_cause = mute_cause || !stream_sel;
        mute_cause = mute_cause || (CTRL_PORT_CFG && st_r.soft_mute);
    end

    // ****************************************
    // Control state
    // ****************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.pins_s1 = {BITSTREAM_MODE_PIN, MODE_SEL_2, MODE_SEL_1, MODE_SEL_0};
        st_nxt.pins_s2 = st_r.pins_s1;
        st_nxt.valid = pair.valid;
        if (pair.valid) begin
            st_nxt.bit_a = pair.chan_a;
            st_nxt.bit_b = pair.chan_b;
        end
        // Control port writes, taken only out of reset
        if (cp_take) begin
            st_nxt.cp_en = CP_EN_WDATA;
            if (cp_take_locked) begin
                st_nxt.power_down_bit = POWER_DOWN_WDATA;
                st_nxt.soft_mute = MUTE_WDATA;
                st_nxt.cp_mode = CP_MODE_WDATA;
            end
        end
        // Ratio check over a fixed window of system clocks
        if (st_r.win_cnt == bitstream_pkg::RATIO_WIN_CYC - 9'h001) begin
            st_nxt.win_cnt = '0;
            st_nxt.edge_cnt = {8'h00, edge_pulse};
            st_nxt.ratio_ok = (st_r.edge_cnt >= edge_min) &&
                (st_r.edge_cnt <= edge_max);
        end else begin
            st_nxt.win_cnt = st_r.win_cnt + 9'h001;
            if (edge_pulse && st_r.edge_cnt != 9'h1FF) begin
                st_nxt.edge_cnt = st_r.edge_cnt + 9'h001;
            end
        end
        unique case (st_r.state)
            bitstream_pkg::ST_LOWPWR: begin
                if (CTRL_PORT_CFG) begin
                    st_nxt.state = bitstream_pkg::ST_WAIT_PDN;
                end else begin
                    st_nxt.state = bitstream_pkg::ST_RUN;
                end
            end
            bitstream_pkg::ST_WAIT_PDN: begin
                if (!CTRL_PORT_CFG || !st_r.power_down_bit) begin
                    st_nxt.state = bitstream_pkg::ST_RUN;
                end
            end
            bitstream_pkg::ST_RUN: begin
                if (CTRL_PORT_CFG && st_r.power_down_bit) begin
                    st_nxt.state = bitstream_pkg::ST_WAIT_PDN;
                end
            end
            default: begin
                st_nxt.state = bitstream_pkg::ST_LOWPWR;
            end
        endcase
        st_nxt.mute = mute_cause;
        if (RST) begin
            // Reset loads every register with its reset value, control port included
            st_nxt = '0;
            st_nxt.state = bitstream_pkg::ST_LOWPWR;
            st_nxt.power_down_bit = bitstream_pkg::PDN_RESET_VAL;
            st_nxt.cp_en = bitstream_pkg::CP_EN_RESET_VAL;
            st_nxt.cp_mode = bitstream_pkg::MODE_RESET_VAL;
            st_nxt.mute = bitstream_pkg::MUTE_RESET_VAL;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        st_r <= st_nxt;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign POWER_DOWN_BIT = st_r.power_down_bit;
    assign CP_ENABLE = st_r.cp_en;
    assign LOW_POWER = st_r.state != bitstream_pkg::ST_RUN;
    assign STREAM_ACTIVE = (st_r.state == bitstream_pkg::ST_RUN) && stream_sel;
    assign RATIO_OK = st_r.ratio_ok;
    assign STREAM_BIT_A = st_r.bit_a;
    assign STREAM_BIT_B = st_r.bit_b;
    assign STREAM_VALID = st_r.valid;
    assign MUTE_CTL_CHAN_A = st_r.mute;
    assign MUTE_CTL_CHAN_B = st_r.mute;

endmodule
`default_nettype wire

// >>> testbench/bitstream_chk.sv
// Assertion checker for the stream input block, bound to its top.
// Assumes the top's port names and one system clock domain.
`timescale 1ns/1ps
`default_nettype none
module bitstream_chk (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CTRL_PORT_CFG,
    input wire logic CP_WRITE,
    input wire logic CP_EN_WDATA,
    input wire logic POWER_DOWN_WDATA,
    input wire logic POWER_DOWN_BIT,
    input wire logic CP_ENABLE,
    input wire logic LOW_POWER,
    input wire logic STREAM_ACTIVE,
    input wire logic RATIO_OK,
    input wire logic STREAM_BIT_A,
    input wire logic STREAM_BIT_B,
    input wire logic STREAM_VALID,
    input wire logic MUTE_CTL_CHAN_A,
    input wire logic MUTE_CTL_CHAN_B
);
    // ****
    // Properties
    // ****
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    a_reset_regs: assert property ($fell(RST) |-> POWER_DOWN_BIT && !CP_ENABLE)
        else $error("control bits not at reset value");
    a_reset_idle: assert property ($fell(RST) |-> LOW_POWER && !RATIO_OK && !STREAM_VALID)
        else $error("not idle after reset");
    a_standalone_run: assert property (!CTRL_PORT_CFG && !$past(RST) |-> !LOW_POWER)
        else $error("stand-alone not running");
    a_enable_write: assert property (CP_WRITE |=> CP_ENABLE == $past(CP_EN_WDATA))
        else $error("enable write lost");
    a_pdn_write: assert property (CP_WRITE && CP_ENABLE |=> POWER_DOWN_BIT == $past(POWER_DOWN_WDATA))
        else $error("power-down write lost");
    a_pdn_locked: assert property (CP_WRITE && !CP_ENABLE |=> $stable(POWER_DOWN_BIT))
        else $error("power-down written while disabled");
    a_wait_pdn: assert property (CTRL_PORT_CFG && POWER_DOWN_BIT |=> LOW_POWER)
        else $error("running with power-down set");
    a_active_run: assert property (STREAM_ACTIVE |-> !LOW_POWER)
        else $error("active in low power");
    a_mute_pair: assert property (MUTE_CTL_CHAN_A == MUTE_CTL_CHAN_B)
        else $error("mute outputs differ");
    a_mute_cause: assert property (!MUTE_CTL_CHAN_A && $past(!MUTE_CTL_CHAN_A)
        |-> $past(!LOW_POWER && RATIO_OK))
        else $error("unmuted while idle or bad ratio");
    a_valid_pulse: assert property (STREAM_VALID |=> !STREAM_VALID)
        else $error("valid longer than one cycle");
    a_bits_valid: assert property ($changed({STREAM_BIT_A, STREAM_BIT_B}) |-> STREAM_VALID)
        else $error("bits changed without valid");
endmodule
bind bitstream_audio_input_ctrl bitstream_chk chk (.SYS_CLK, .RST, .CTRL_PORT_CFG, .CP_WRITE,
    .CP_EN_WDATA, .POWER_DOWN_WDATA, .POWER_DOWN_BIT, .CP_ENABLE, .LOW_POWER, .STREAM_ACTIVE,
    .RATIO_OK, .STREAM_BIT_A, .STREAM_BIT_B, .STREAM_VALID, .MUTE_CTL_CHAN_A, .MUTE_CTL_CHAN_B);
`default_nettype wire

// >>> testbench/stream_source_model.sv
// Stream source: bit clock and two data lines, data set up on the fall.
// Assumes the bench gives the half period in ns; clock stands low when idle.
`timescale 1ns/1ps
`default_nettype none
module stream_source_model (
    input wire logic run,
    input wire logic [31:0] half_ns,
    output logic bit_clk,
    output logic chan_a,
    output logic chan_b
);
    int seed = 79087;
    logic [1:0] last;
    logic [1:0] sent_q[$];
    // ****
    // Clock and data
    // ****
    initial begin
        {bit_clk, chan_a, chan_b, last} = 5'h00;
        #7;
        forever begin
            if (run) begin
                #half_ns;
                bit_clk = 1'b1;
                last = {chan_a, chan_b};
                sent_q.push_back(last);
                #half_ns;
                bit_clk = 1'b0;
                {chan_a, chan_b} = 2'($random(seed));
            end else begin
                #half_ns;
                {chan_a, chan_b} = ~last;
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/bitstream_audio_input_ctrl_tb.sv
// Self-checking bench for the stream input block.
// Assumes the source model and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module bitstream_audio_input_ctrl_tb;
    logic SYS_CLK, RST, CTRL_PORT_CFG, CP_WRITE, CP_EN_WDATA, POWER_DOWN_WDATA, MUTE_WDATA;
    logic BITSTREAM_MODE_PIN, MODE_SEL_2, MODE_SEL_1, MODE_SEL_0, run, chk_data;
    logic [2:0] CP_MODE_WDATA;
    logic [1:0] got;
    wire STREAM_BIT_CLOCK, STREAM_IN_CHAN_A, STREAM_IN_CHAN_B;
    logic POWER_DOWN_BIT, CP_ENABLE, LOW_POWER, STREAM_ACTIVE, RATIO_OK;
    logic STREAM_BIT_A, STREAM_BIT_B, STREAM_VALID, MUTE_CTL_CHAN_A, MUTE_CTL_CHAN_B;
    int half_ns, code, seed = 79087, fails = 0, n_compared = 0;
    bitstream_audio_input_ctrl dut (.SYS_CLK, .RST, .STREAM_BIT_CLOCK, .STREAM_IN_CHAN_A,
        .STREAM_IN_CHAN_B, .BITSTREAM_MODE_PIN, .MODE_SEL_2, .MODE_SEL_1, .MODE_SEL_0,
        .CTRL_PORT_CFG, .CP_WRITE, .CP_EN_WDATA, .POWER_DOWN_WDATA, .MUTE_WDATA,
        .CP_MODE_WDATA, .POWER_DOWN_BIT, .CP_ENABLE, .LOW_POWER, .STREAM_ACTIVE, .RATIO_OK,
        .STREAM_BIT_A, .STREAM_BIT_B, .STREAM_VALID, .MUTE_CTL_CHAN_A, .MUTE_CTL_CHAN_B);
    stream_source_model src (.run, .half_ns, .bit_clk(STREAM_BIT_CLOCK),
        .chan_a(STREAM_IN_CHAN_A), .chan_b(STREAM_IN_CHAN_B));
    // ****
    // Helpers
    // ****
    task automatic cmp(input string what, input logic [2:0] exp, input logic [2:0] seen);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge SYS_CLK);
        #5;
    endtask
    task automatic chk_state(input logic lp, input logic ok, input logic act);
        cmp("low power", 3'(lp), 3'(LOW_POWER));
        cmp("ratio ok", 3'(ok), 3'(RATIO_OK));
        cmp("active", 3'(act), 3'(STREAM_ACTIVE));
        cmp("mutes", {1'b0, {2{~(ok & act)}}}, {1'b0, MUTE_CTL_CHAN_A, MUTE_CTL_CHAN_B});
    endtask
    task automatic cp_wr(input logic en, input logic pd, input logic mu);
        {CP_WRITE, CP_EN_WDATA, POWER_DOWN_WDATA, MUTE_WDATA} = {1'b1, en, pd, mu};
        tick(1);
    endtask
    function automatic int half_for(input int c);
        int r [8] = '{4, 6, 8, 12, 2, 3, 4, 6};
        return r[c % 8] * 20;
    endfunction
    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ****
    // Clock, watchdog and captured data
    // ****
    initial begin
        SYS_CLK = 1'b0;
        forever #20 SYS_CLK = ~SYS_CLK;
    end
    initial begin
        #800000;
        fails++;
        end_sim;
    end
    always @(negedge SYS_CLK) begin
        if (chk_data && STREAM_VALID === 1'b1) begin
            got = {STREAM_BIT_A, STREAM_BIT_B};
            cmp("pair", 3'(src.sent_q.size() > 0 ? src.sent_q.pop_front() : ~got), 3'(got));
        end
    end
    // ****
    // Scenarios
    // ****
    initial begin
        {RST, CTRL_PORT_CFG, CP_WRITE, CP_EN_WDATA, POWER_DOWN_WDATA, MUTE_WDATA} = 6'h20;
        {BITSTREAM_MODE_PIN, MODE_SEL_2, MODE_SEL_1, MODE_SEL_0, CP_MODE_WDATA} = 7'h40;
        {run, chk_data} = 2'h2;
        half_ns = 80;
        tick(12);
        chk_state(1'b1, 1'b0, 1'b0);
        cmp("pdn and enable", 3'h2, {1'b0, POWER_DOWN_BIT, CP_ENABLE});
        RST = 1'b0;
        tick(20);
        run = 1'b0;
        tick(40);
        src.sent_q.delete();
        {run, chk_data} = 2'h3;
        for (int c = 0; c < 9; c++) begin
            {MODE_SEL_2, MODE_SEL_1, MODE_SEL_0} = 3'(c);
            half_ns = half_for(c) + (c / 8) * 20;
            tick(800);
            chk_state(1'b0, c < 8, 1'b1);
        end
        half_ns = half_for(0);
        tick(800);
        BITSTREAM_MODE_PIN = 1'b0;
        tick(6);
        cmp("active and mute", 3'h3, {STREAM_ACTIVE, MUTE_CTL_CHAN_A, MUTE_CTL_CHAN_B});
        chk_data = 1'b0;
        code = $random(seed) & 7;
        CP_MODE_WDATA = 3'(code);
        {MODE_SEL_2, MODE_SEL_1, MODE_SEL_0} = ~3'(code);
        half_ns = half_for(code);
        {RST, CTRL_PORT_CFG, BITSTREAM_MODE_PIN} = 3'h7;
        cp_wr(1'b1, 1'b0, 1'b0);
        CP_WRITE = 1'b0;
        tick(11);
        RST = 1'b0;
        tick(3);
        cp_wr(1'b0, 1'b0, 1'b0);
        CP_WRITE = 1'b0;
        tick(3);
        cmp("pdn and enable", 3'h2, {1'b0, POWER_DOWN_BIT, CP_ENABLE});
        cmp("low power", 3'h1, 3'(LOW_POWER));
        cp_wr(1'b1, 1'b1, 1'b0);
        cp_wr(1'b1, 1'b0, 1'b0);
        CP_WRITE = 1'b0;
        tick(800);
        chk_state(1'b0, 1'b1, 1'b1);
        cp_wr(1'b1, 1'b0, 1'b1);
        CP_WRITE = 1'b0;
        tick(3);
        cmp("mute bit", 3'h3, {1'b0, MUTE_CTL_CHAN_A, MUTE_CTL_CHAN_B});
        cp_wr(1'b1, 1'b1, 1'b0);
        CP_WRITE = 1'b0;
        tick(3);
        cmp("power down", 3'h7, {POWER_DOWN_BIT, LOW_POWER, MUTE_CTL_CHAN_A});
        end_sim;
    end
endmodule
`default_nettype wire
